/* rtl/dpw_pkg.sv */
package dpw_pkg;

  // ==========================================================
  // Register map (byte-wide special function registers)
  // ==========================================================
  localparam logic [7:0] ADDR_MODULATOR_CONTROL = 8'hAE;
  localparam logic [7:0] ADDR_PULSE_WIDTH_LOW   = 8'hB1;
  localparam logic [7:0] ADDR_PULSE_WIDTH_HIGH  = 8'hB2;
  localparam logic [7:0] ADDR_CYCLE_WIDTH_LOW   = 8'hB3;
  localparam logic [7:0] ADDR_CYCLE_WIDTH_HIGH  = 8'hB4;
  localparam logic [7:0] RESET_BYTE             = 8'h00;
  localparam logic [7:0] UNMAPPED_READ          = 8'h00;

  // ==========================================================
  // Control field positions
  // ==========================================================
  localparam int MODE_LSB  = 4;
  localparam int PRESC_LSB = 2;
  localparam int SRC_LSB   = 0;

  // ==========================================================
  // Clock source and prescaler constants
  // ==========================================================
  localparam logic [3:0] XTAL_DIV_LAST = 4'hE;   // Crystal divided by 15
  localparam logic [3:0] XTAL_DIV_HALF = 4'h7;
  localparam logic [5:0] PRESC_LAST_1  = 6'h00;
  localparam logic [5:0] PRESC_LAST_4  = 6'h03;
  localparam logic [5:0] PRESC_LAST_16 = 6'h0F;
  localparam logic [5:0] PRESC_LAST_64 = 6'h3F;
  localparam logic [15:0] CNT_FULL     = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;

  typedef enum logic [2:0] {
    DPW_OFF,
    DPW_SINGLE16,
    DPW_TWIN8,
    DPW_TWIN16,
    DPW_NRZ16,
    DPW_DUAL8,
    DPW_RZ16,
    DPW_HOLD
  } dpw_mode_t;

  typedef enum logic [1:0] {
    DPW_SRC_XTAL15,
    DPW_SRC_XTAL,
    DPW_SRC_EXT,
    DPW_SRC_PLL
  } dpw_src_t;

  typedef struct packed {
    logic      spare;
    dpw_mode_t mode_sel;
    logic [1:0] clock_prescale_sel;
    dpw_src_t  clock_source_sel;
  } dpw_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } dpw_sfr_req_t;

  typedef struct packed {
    logic o;
    logic oe;
  } dpw_pin_t;

endpackage : dpw_pkg

/* rtl/dpw_modulator.sv */
`timescale 1ns/10ps
// Operation
// - Three-bit mode field selects one of eight operating modes
// - Prescaler divides selected source by 1, 4, 16 or 64
// - Source select: crystal/15, crystal, external pin, PLL clock
// - Any control write resets the shared counter
// - 16-bit modes: low byte goes to hidden holder; high write updates both bytes
// - New 16-bit values take effect from the next cycle or a control write
// - Disabled mode releases both pins for ordinary I/O
// - Single mode: cycle pair sets the waveform period
// - Single mode: pulse pair sets the high time per period
// - Twin 8-bit: cycle low byte sets common period
// - Twin 8-bit: first output low when counter equals pulse low
// - Twin 8-bit: second output high at cycle high, low at pulse high
// - Twin 16-bit: counter runs full 16-bit range and wraps
// - Twin 16-bit: output high below its value, low from equality
// - Twin 16-bit: both outputs go high together at wrap
// - NRZ density: outputs updated every counter clock
// - NRZ density: high for register value clocks per 65536
// - Dual 8-bit: each output has its own duty and period
// - Held-reset mode keeps counter reset and pins undriven
// - RZ density: each high clock is half high, half low
module dpw_modulator
  import dpw_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire dpw_sfr_req_t sfr_req,
  output logic [7:0]        sfr_rdata,
  input  wire logic         crystal_clock,
  input  wire logic         ext_clock_pin,
  input  wire logic         pll_clock,
  output dpw_pin_t          wave_pin_a,
  output dpw_pin_t          wave_pin_b
);

  // ==========================================================
  // Register file
  // ==========================================================
  dpw_ctrl_t   ctrl_q, ctrl_d;
  logic [15:0] pulse_q, pulse_d, cycle_q, cycle_d;
  logic [7:0]  hold_pulse_q, hold_pulse_d, hold_cycle_q, hold_cycle_d;
  logic [15:0] act_pulse_q, act_pulse_d, act_cycle_q, act_cycle_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        ctrl_wr;
  logic        wide_mode;
  logic        cycle_end;
  logic        cnt_tick;

  assign ctrl_wr   = sfr_req.wr && (sfr_req.addr == ADDR_MODULATOR_CONTROL);
  assign wide_mode = (ctrl_q.mode_sel == DPW_SINGLE16) || (ctrl_q.mode_sel == DPW_TWIN16)
                  || (ctrl_q.mode_sel == DPW_NRZ16) || (ctrl_q.mode_sel == DPW_RZ16);

  // Byte writes, shadowing and the active copies the comparators use
  always_comb
  begin
    ctrl_d       = ctrl_q;
    pulse_d      = pulse_q;
    cycle_d      = cycle_q;
    hold_pulse_d = hold_pulse_q;
    hold_cycle_d = hold_cycle_q;
    act_pulse_d  = act_pulse_q;
    act_cycle_d  = act_cycle_q;
    if (ctrl_wr)
    begin
      ctrl_d = dpw_ctrl_t'(sfr_req.wdata);
    end
    else if (sfr_req.wr && wide_mode)
    begin
      // Low byte parks in the holder so a half-written pair is never seen
      if (sfr_req.addr == ADDR_PULSE_WIDTH_LOW)
      begin
        hold_pulse_d = sfr_req.wdata;
      end
      else if (sfr_req.addr == ADDR_PULSE_WIDTH_HIGH)
      begin
        pulse_d = {sfr_req.wdata, hold_pulse_q};
      end
      else if (sfr_req.addr == ADDR_CYCLE_WIDTH_LOW)
      begin
        hold_cycle_d = sfr_req.wdata;
      end
      else if (sfr_req.addr == ADDR_CYCLE_WIDTH_HIGH)
      begin
        cycle_d = {sfr_req.wdata, hold_cycle_q};
      end
    end
    else if (sfr_req.wr)
    begin
      // 8-bit modes have no pair to protect, so bytes land directly
      if (sfr_req.addr == ADDR_PULSE_WIDTH_LOW)
      begin
        pulse_d[7:0] = sfr_req.wdata;
      end
      else if (sfr_req.addr == ADDR_PULSE_WIDTH_HIGH)
      begin
        pulse_d[15:8] = sfr_req.wdata;
      end
      else if (sfr_req.addr == ADDR_CYCLE_WIDTH_LOW)
      begin
        cycle_d[7:0] = sfr_req.wdata;
      end
      else if (sfr_req.addr == ADDR_CYCLE_WIDTH_HIGH)
      begin
        cycle_d[15:8] = sfr_req.wdata;
      end
    end
    // Active values follow at cycle end or on a control write in wide modes
    if (!wide_mode || ctrl_wr || (cnt_tick && cycle_end))
    begin
      act_pulse_d = pulse_q;
      act_cycle_d = cycle_q;
    end
  end

  // Read data is registered; unmapped addresses read as zero
  always_comb
  begin
    if (sfr_req.addr == ADDR_MODULATOR_CONTROL)
    begin
      rdata_d = ctrl_q;
    end
    else if (sfr_req.addr == ADDR_PULSE_WIDTH_LOW)
    begin
      rdata_d = pulse_q[7:0];
    end
    else if (sfr_req.addr == ADDR_PULSE_WIDTH_HIGH)
    begin
      rdata_d = pulse_q[15:8];
    end
    else if (sfr_req.addr == ADDR_CYCLE_WIDTH_LOW)
    begin
      rdata_d = cycle_q[7:0];
    end
    else if (sfr_req.addr == ADDR_CYCLE_WIDTH_HIGH)
    begin
      rdata_d = cycle_q[15:8];
    end
    else
    begin
      rdata_d = UNMAPPED_READ;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_q       <= dpw_ctrl_t'(RESET_BYTE);
      pulse_q      <= {RESET_BYTE, RESET_BYTE};
      cycle_q      <= {RESET_BYTE, RESET_BYTE};
      hold_pulse_q <= RESET_BYTE;
      hold_cycle_q <= RESET_BYTE;
      act_pulse_q  <= {RESET_BYTE, RESET_BYTE};
      act_cycle_q  <= {RESET_BYTE, RESET_BYTE};
      rdata_q      <= RESET_BYTE;
    end
    else
    begin
      ctrl_q       <= ctrl_d;
      pulse_q      <= pulse_d;
      cycle_q      <= cycle_d;
      hold_pulse_q <= hold_pulse_d;
      hold_cycle_q <= hold_cycle_d;
      act_pulse_q  <= act_pulse_d;
      act_cycle_q  <= act_cycle_d;
      rdata_q      <= rdata_d;
    end
  end

  assign sfr_rdata = rdata_q;

  // ==========================================================
  // Clock source selection and prescaler
  // ==========================================================
  logic [2:0] lvl_q;
  logic [3:0] xdiv_q, xdiv_d;
  logic [5:0] presc_q, presc_d;
  logic [5:0] presc_last;
  logic       xtal_rise, src_tick, src_half, half_tick;

  // Source inputs are synchronous levels; edges are found by one delay
  assign xtal_rise = crystal_clock && !lvl_q[0];

  always_comb
  begin
    src_tick = 1'b0;
    src_half = 1'b0;
    case (ctrl_q.clock_source_sel)
      DPW_SRC_XTAL15:
      begin
        src_tick = xtal_rise && (xdiv_q == XTAL_DIV_LAST);
        src_half = xtal_rise && (xdiv_q == XTAL_DIV_HALF);
      end
      DPW_SRC_XTAL:
      begin
        src_tick = xtal_rise;
        src_half = !crystal_clock && lvl_q[0];
      end
      DPW_SRC_EXT:
      begin
        src_tick = ext_clock_pin && !lvl_q[1];
        src_half = !ext_clock_pin && lvl_q[1];
      end
      default:
      begin
        src_tick = pll_clock && !lvl_q[2];
        src_half = !pll_clock && lvl_q[2];
      end
    endcase
    case (ctrl_q.clock_prescale_sel)
      2'b00:   presc_last = PRESC_LAST_1;
      2'b01:   presc_last = PRESC_LAST_4;
      2'b10:   presc_last = PRESC_LAST_16;
      default: presc_last = PRESC_LAST_64;
    endcase
    xdiv_d = xdiv_q;
    if (xtal_rise)
    begin
      xdiv_d = (xdiv_q == XTAL_DIV_LAST) ? 4'h0 : xdiv_q + 4'h1;
    end
    presc_d = presc_q;
    if (ctrl_wr)
    begin
      presc_d = 6'h00;
    end
    else if (src_tick)
    begin
      presc_d = (presc_q == presc_last) ? 6'h00 : presc_q + 6'h01;
    end
  end

  assign cnt_tick  = src_tick && (presc_q == presc_last);
  // Mid-period mark used to return the density output to zero
  assign half_tick = (presc_last == PRESC_LAST_1) ? src_half
                   : (src_tick && (presc_q == (presc_last >> 1)));

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      lvl_q   <= 3'h0;
      xdiv_q  <= 4'h0;
      presc_q <= 6'h00;
    end
    else
    begin
      lvl_q   <= {pll_clock, ext_clock_pin, crystal_clock};
      xdiv_q  <= xdiv_d;
      presc_q <= presc_d;
    end
  end

  // ==========================================================
  // Shared counter and density accumulators
  // ==========================================================
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] acc_q [2];
  logic [15:0] acc_d [2];
  logic [1:0]  carry;
  logic        lo_wrap, hi_wrap;

  assign lo_wrap = cnt_q[7:0] == act_cycle_q[7:0];
  assign hi_wrap = cnt_q[15:8] == act_cycle_q[15:8];

  always_comb
  begin
    case (ctrl_q.mode_sel)
      DPW_SINGLE16: cycle_end = cnt_q == act_cycle_q;
      DPW_TWIN8:    cycle_end = lo_wrap;
      DPW_DUAL8:    cycle_end = lo_wrap;
      default:      cycle_end = cnt_q == CNT_FULL;
    endcase
    cnt_d = cnt_q;
    if (ctrl_wr || (ctrl_q.mode_sel == DPW_OFF) || (ctrl_q.mode_sel == DPW_HOLD))
    begin
      cnt_d = CNT_ZERO;
    end
    else if (cnt_tick && (ctrl_q.mode_sel == DPW_DUAL8))
    begin
      // Each byte runs its own period for its own output
      cnt_d[7:0]  = lo_wrap ? 8'h00 : cnt_q[7:0] + 8'h01;
      cnt_d[15:8] = hi_wrap ? 8'h00 : cnt_q[15:8] + 8'h01;
    end
    else if (cnt_tick)
    begin
      cnt_d = cycle_end ? CNT_ZERO : cnt_q + 16'h0001;
    end
  end

  // One first-order accumulator per channel; carry out is the bit stream
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_acc
    logic [15:0] val;
    logic [16:0] sum;
    assign val       = (ch == 0) ? act_pulse_q : act_cycle_q;
    assign sum       = {1'b0, acc_q[ch]} + {1'b0, val};
    assign carry[ch] = sum[16];
    assign acc_d[ch] = ctrl_wr ? CNT_ZERO : (cnt_tick ? sum[15:0] : acc_q[ch]);
    always_ff @(posedge core_clk)
    begin
      if (rst)
      begin
        acc_q[ch] <= CNT_ZERO;
      end
      else
      begin
        acc_q[ch] <= acc_d[ch];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cnt_q <= CNT_ZERO;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // Output waveforms
  // ==========================================================
  dpw_pin_t pin_a_q, pin_a_d, pin_b_q, pin_b_d;

  always_comb
  begin
    pin_a_d = pin_a_q;
    pin_b_d = pin_b_q;
    pin_a_d.oe = 1'b1;
    pin_b_d.oe = 1'b1;
    case (ctrl_q.mode_sel)
      DPW_SINGLE16:
      begin
        pin_a_d.o  = cnt_q < act_pulse_q;
        pin_b_d.oe = 1'b0;
        pin_b_d.o  = 1'b0;
      end
      DPW_TWIN8:
      begin
        if (cnt_q[7:0] == act_pulse_q[7:0])
        begin
          pin_a_d.o = 1'b0;
        end
        else if (cnt_q[7:0] == 8'h00)
        begin
          pin_a_d.o = 1'b1;
        end
        if (cnt_q[7:0] == act_pulse_q[15:8])
        begin
          pin_b_d.o = 1'b0;
        end
        else if (cnt_q[7:0] == act_cycle_q[15:8])
        begin
          pin_b_d.o = 1'b1;
        end
      end
      DPW_TWIN16:
      begin
        // Both high below their value, so both rise together at zero
        pin_a_d.o = cnt_q < act_pulse_q;
        pin_b_d.o = cnt_q < act_cycle_q;
      end
      DPW_NRZ16:
      begin
        if (cnt_tick)
        begin
          pin_a_d.o = carry[0];
          pin_b_d.o = carry[1];
        end
      end
      DPW_RZ16:
      begin
        if (cnt_tick)
        begin
          pin_a_d.o = carry[0];
          pin_b_d.o = carry[1];
        end
        else if (half_tick)
        begin
          pin_a_d.o = 1'b0;
          pin_b_d.o = 1'b0;
        end
      end
      DPW_DUAL8:
      begin
        pin_a_d.o = cnt_q[7:0] < act_pulse_q[7:0];
        pin_b_d.o = cnt_q[15:8] < act_pulse_q[15:8];
      end
      default:
      begin
        // Off and held-reset modes leave the pins to the port logic
        pin_a_d = '0;
        pin_b_d = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pin_a_q <= '0;
      pin_b_q <= '0;
    end
    else
    begin
      pin_a_q <= pin_a_d;
      pin_b_q <= pin_b_d;
    end
  end

  assign wave_pin_a = pin_a_q;
  assign wave_pin_b = pin_b_q;

endmodule : dpw_modulator

/* bench/dpw_modulator_props.sv */
`timescale 1ns/10ps
// ==========================================================
// Port-level checker for the dual modulator
// ==========================================================
module dpw_checker
  import dpw_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         rst,
  input wire dpw_sfr_req_t sfr_req,
  input wire logic [7:0]   sfr_rdata,
  input wire logic         crystal_clock,
  input wire logic         ext_clock_pin,
  input wire logic         pll_clock,
  input wire dpw_pin_t     wave_pin_a,
  input wire dpw_pin_t     wave_pin_b
);
  dpw_mode_t mode_q;
  dpw_mode_t mode_d;
  logic      wide;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Shadow of the mode field, followed from control writes
  always_comb
  begin
    mode_d = mode_q;
    if (sfr_req.wr && sfr_req.addr == ADDR_MODULATOR_CONTROL)
      mode_d = dpw_mode_t'(sfr_req.wdata[MODE_LSB +: 3]);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      mode_q <= DPW_OFF;
    else
      mode_q <= mode_d;
  end

  // Wide modes route low-byte writes through the hidden holder
  assign wide = mode_q inside {DPW_SINGLE16, DPW_TWIN16, DPW_NRZ16, DPW_RZ16};

  // ==========================================================
  // Bus steps
  // ==========================================================
  sequence s_wr(a);
    sfr_req.wr && sfr_req.addr == a;
  endsequence

  sequence s_rd(a);
    !sfr_req.wr && sfr_req.addr == a;
  endsequence

  // ==========================================================
  // Assertions
  // ==========================================================
  AST_CTRL_READBACK: assert property (
    s_wr(ADDR_MODULATOR_CONTROL) ##1 s_rd(ADDR_MODULATOR_CONTROL)
    |=> sfr_rdata == $past(sfr_req.wdata, 2)) else $error("control readback wrong");
  AST_LOW_HIDDEN: assert property (
    s_rd(ADDR_PULSE_WIDTH_LOW) ##1 (s_wr(ADDR_PULSE_WIDTH_LOW) and wide) ##1
    s_rd(ADDR_PULSE_WIDTH_LOW) |=> sfr_rdata == $past(sfr_rdata, 2))
    else $error("low byte changed before high write");
  AST_HIGH_PAIR: assert property (
    (s_wr(ADDR_PULSE_WIDTH_LOW) and wide) ##1 s_wr(ADDR_PULSE_WIDTH_HIGH) ##1
    s_rd(ADDR_PULSE_WIDTH_LOW) |=> sfr_rdata == $past(sfr_req.wdata, 3))
    else $error("high write did not copy holder");
  AST_DIRECT8: assert property (
    (s_wr(ADDR_PULSE_WIDTH_LOW) and !wide) ##1 s_rd(ADDR_PULSE_WIDTH_LOW)
    |=> sfr_rdata == $past(sfr_req.wdata, 2)) else $error("byte write not direct");
  AST_OFF_RELEASE: assert property (
    mode_q == DPW_OFF |=> !wave_pin_a.oe && !wave_pin_b.oe)
    else $error("pins driven while disabled");
  AST_HOLD_RELEASE: assert property (
    (mode_q == DPW_HOLD) [*2] |-> !wave_pin_a.oe && !wave_pin_b.oe)
    else $error("pins driven while held");
  AST_ACTIVE_DRIVE: assert property (
    mode_q inside {DPW_TWIN8, DPW_TWIN16, DPW_NRZ16, DPW_DUAL8, DPW_RZ16}
    |=> wave_pin_a.oe && wave_pin_b.oe) else $error("active mode left a pin free");
  AST_SINGLE_ONE_PIN: assert property (
    mode_q == DPW_SINGLE16 |=> wave_pin_a.oe && !wave_pin_b.oe)
    else $error("single mode pin drive wrong");
endmodule : dpw_checker

bind dpw_modulator dpw_checker dpw_checker_inst (
  .core_clk      (core_clk),
  .rst           (rst),
  .sfr_req       (sfr_req),
  .sfr_rdata     (sfr_rdata),
  .crystal_clock (crystal_clock),
  .ext_clock_pin (ext_clock_pin),
  .pll_clock     (pll_clock),
  .wave_pin_a    (wave_pin_a),
  .wave_pin_b    (wave_pin_b)
);

/* bench/dpw_pin_load.sv */
`timescale 1ns/10ps
// ==========================================================
// Port pins with pull-ups feeding a load; counts high clocks
// ==========================================================
module dpw_pin_load
  import dpw_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     clr,
  input  wire dpw_pin_t wave_pin_a,
  input  wire dpw_pin_t wave_pin_b,
  output logic          pad_a,
  output logic          pad_b,
  output logic [15:0]   hi_a_q,
  output logic [15:0]   hi_b_q
);
  // A released pin floats up to the pull-up, never to the last value
  assign pad_a = wave_pin_a.oe ? wave_pin_a.o : 1'b1;
  assign pad_b = wave_pin_b.oe ? wave_pin_b.o : 1'b1;

  // High clocks since the last clear, as a filter would average them
  always_ff @(posedge core_clk)
  begin
    if (clr)
    begin
      hi_a_q <= 16'h0000;
      hi_b_q <= 16'h0000;
    end
    else
    begin
      hi_a_q <= hi_a_q + 16'(pad_a);
      hi_b_q <= hi_b_q + 16'(pad_b);
    end
  end
endmodule : dpw_pin_load

/* bench/dpw_modulator_tb_top.sv */
`timescale 1ns/10ps
module dpw_modulator_tb_top
  import dpw_pkg::*;
();
  logic         core_clk;
  logic         rst;
  logic         clr;
  logic [7:0]   src_q = 8'h00;
  logic [7:0]   rv;
  dpw_sfr_req_t sfr_req;
  logic [7:0]   sfr_rdata;
  dpw_pin_t     wave_pin_a;
  dpw_pin_t     wave_pin_b;
  logic         pad_a;
  logic         pad_b;
  logic [15:0]  hi_a;
  logic [15:0]  hi_b;
  int           fails;
  int           n_checks;

  // ==========================================================
  // Clock, source clocks and instances
  // ==========================================================
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Sources rise every 2, 4 and 8 clocks: pll, external, crystal
  always @(posedge core_clk)
    src_q <= src_q + 8'h01;

  dpw_modulator dpw_modulator_inst (
    .core_clk      (core_clk),
    .rst           (rst),
    .sfr_req       (sfr_req),
    .sfr_rdata     (sfr_rdata),
    .crystal_clock (src_q[2]),
    .ext_clock_pin (src_q[1]),
    .pll_clock     (src_q[0]),
    .wave_pin_a    (wave_pin_a),
    .wave_pin_b    (wave_pin_b)
  );

  dpw_pin_load dpw_pin_load_inst (
    .core_clk   (core_clk),
    .clr        (clr),
    .wave_pin_a (wave_pin_a),
    .wave_pin_b (wave_pin_b),
    .pad_a      (pad_a),
    .pad_b      (pad_b),
    .hi_a_q     (hi_a),
    .hi_b_q     (hi_b)
  );

  // ==========================================================
  // Bus and checking tasks
  // ==========================================================
  task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge core_clk);
    sfr_req <= '{a, w, d};
  endtask : bus

  task rd(input logic [7:0] a);
    bus(a, 1'b0, 8'h00);
    bus(a, 1'b0, 8'h00);
    #1 rv = sfr_rdata;
  endtask : rd

  task w8(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
    bus(a, 1'b0, 8'h00);
  endtask : w8

  // Low byte strictly before high byte
  task wpair(input logic [7:0] a, input logic [15:0] v);
    bus(a, 1'b1, v[7:0]);
    bus(a + 8'h01, 1'b1, v[15:8]);
    bus(a, 1'b0, 8'h00);
  endtask : wpair

  // Count pad high clocks over a window of n clocks
  task meas(input int n);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
  endtask : meas

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wrap_up;
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Scenarios
  // ==========================================================
  task t_regs;
    logic [7:0] a_t [6];
    a_t = '{8'hAE, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB0};
    for (int i = 0; i < 6; i++)
    begin
      rd(a_t[i]);
      chk({8'h00, rv}, 16'h0000);
    end
    w8(ADDR_MODULATOR_CONTROL, 8'h80);
    rd(ADDR_MODULATOR_CONTROL);
    chk({8'h00, rv}, 16'h0080);
    chk({14'h0, wave_pin_a.oe, wave_pin_b.oe}, 16'h0000);
    w8(ADDR_MODULATOR_CONTROL, 8'hF3);
    repeat (3) @(posedge core_clk);
    #1 chk({14'h0, wave_pin_a.oe, wave_pin_b.oe}, 16'h0000);
  endtask : t_regs

  // Every source and divider code; the PLL divide-by-64 case costs most
  task t_twin8;
    logic [7:0] ctl_t [7];
    int         cpt_t [7];
    ctl_t = '{8'h23, 8'h22, 8'h21, 8'h20, 8'h27, 8'h2B, 8'h2F};
    cpt_t = '{2, 4, 8, 120, 8, 32, 128};
    w8(ADDR_PULSE_WIDTH_LOW, 8'h04);
    w8(ADDR_PULSE_WIDTH_HIGH, 8'h07);
    w8(ADDR_CYCLE_WIDTH_LOW, 8'h09);
    w8(ADDR_CYCLE_WIDTH_HIGH, 8'h02);
    for (int i = 0; i < 7; i++)
    begin
      w8(ADDR_MODULATOR_CONTROL, ctl_t[i]);
      repeat (2 * cpt_t[i]) @(posedge core_clk);
      meas(20 * cpt_t[i]);
      chk(hi_a, 16'(8 * cpt_t[i]));
      chk(hi_b, 16'(10 * cpt_t[i]));
    end
  endtask : t_twin8

  task t_dual8;
    w8(ADDR_PULSE_WIDTH_LOW, 8'h02);
    w8(ADDR_PULSE_WIDTH_HIGH, 8'h01);
    w8(ADDR_CYCLE_WIDTH_LOW, 8'h04);
    w8(ADDR_CYCLE_WIDTH_HIGH, 8'h03);
    w8(ADDR_MODULATOR_CONTROL, 8'h53);
    repeat (4) @(posedge core_clk);
    meas(200);
    chk(hi_a, 16'd80);
    chk(hi_b, 16'd50);
  endtask : t_dual8

  task t_single;
    w8(ADDR_MODULATOR_CONTROL, 8'h13);
    wpair(ADDR_PULSE_WIDTH_LOW, 16'h0003);
    wpair(ADDR_CYCLE_WIDTH_LOW, 16'h0009);
    rd(ADDR_PULSE_WIDTH_LOW);
    chk({8'h00, rv}, 16'h0003);
    w8(ADDR_MODULATOR_CONTROL, 8'h13);
    repeat (4) @(posedge core_clk);
    meas(200);
    chk(hi_a, 16'd60);
    chk(hi_b, 16'd200);
  endtask : t_single

  // Counter left mid-period by the single mode must restart at zero
  task t_twin16;
    w8(ADDR_MODULATOR_CONTROL, 8'h33);
    wpair(ADDR_CYCLE_WIDTH_LOW, 16'h0030);
    w8(ADDR_MODULATOR_CONTROL, 8'h33);
    repeat (2) @(posedge core_clk);
    #1 chk({14'h0, pad_a, pad_b}, 16'h0003);
    repeat (40) @(posedge core_clk);
    #1 chk({14'h0, pad_a, pad_b}, 16'h0001);
  endtask : t_twin16

  task t_density;
    w8(ADDR_MODULATOR_CONTROL, 8'h43);
    bus(ADDR_PULSE_WIDTH_LOW, 1'b0, 8'h00);
    bus(ADDR_PULSE_WIDTH_LOW, 1'b1, 8'hAA);
    rd(ADDR_PULSE_WIDTH_LOW);
    chk({8'h00, rv}, 16'h0003);
    wpair(ADDR_PULSE_WIDTH_LOW, 16'h2000);
    wpair(ADDR_CYCLE_WIDTH_LOW, 16'h1000);
    w8(ADDR_MODULATOR_CONTROL, 8'h43);
    wpair(ADDR_PULSE_WIDTH_LOW, 16'h8000);
    meas(280);
    chk(hi_a, 16'd34);
    chk(hi_b, 16'd16);
    // Low bits cleared with a one in the LSB; carries keep the same spacing
    wpair(ADDR_PULSE_WIDTH_LOW, 16'h2001);
    w8(ADDR_MODULATOR_CONTROL, 8'h63);
    meas(280);
    chk(hi_a, 16'd17);
    chk(hi_b, 16'd8);
  endtask : t_density

  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial
  begin
    rst = 1'b1;
    clr = 1'b0;
    sfr_req = '{8'h00, 1'b0, 8'h00};
    fails = 0;
    n_checks = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_twin8();
    t_dual8();
    t_single();
    t_twin16();
    t_density();
    wrap_up();
  end

  // About 7800 clocks expected; allow twice that and more
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    wrap_up();
  end
endmodule : dpw_modulator_tb_top
